/* ooo_consts.svh */
// Constants for the out-of-order issue and retirement control block.
`ifndef OOO_CONSTS_SVH
`define OOO_CONSTS_SVH
`define OOO_RS_N 36
`define OOO_RS_RSV 6'h04
`define OOO_RS_FULL 6'h24
`define OOO_ROB_N 128
`define OOO_ROB_CAP1 8'h80
`define OOO_ROB_CAP2 8'h40
`define OOO_T1_BASE 7'h40
`define OOO_PORTS 6
`define OOO_WIDTH 4
`define OOO_FETCH_B 5'h10
`define OOO_ITB_N 128
`define OOO_RESET_PC 32'h0000_0000
`endif

/* ooo_pkg.sv */
// Types for the out-of-order issue and retirement control block.
`include "ooo_consts.svh"
package ooo_pkg;
   typedef enum logic {OOO_F_RUN, OOO_F_WALK} ooo_fetch_t;
   typedef struct packed {
      logic v;
      logic done;
      logic last;
      logic [4:0] dest;
   } ooo_rob_ent_t;
   typedef struct packed {
      logic v;
      logic thr;
      logic [6:0] reorder_buffer;
      logic [2:0] port;
      logic dv;
      logic [6:0] dep;
   } ooo_rs_ent_t;
   typedef struct packed {
      logic v;
      logic [12:0] tag;
      logic [19:0] ppn;
   } ooo_itb_ent_t;
   typedef struct packed {
      ooo_fetch_t fst;
      logic [31:0] pc;
      ooo_itb_ent_t [`OOO_ITB_N-1:0] itb;
      ooo_rob_ent_t [`OOO_ROB_N-1:0] reorder_buffer;
      ooo_rs_ent_t [`OOO_RS_N-1:0] rs;
      logic [1:0][6:0] head;
      logic [1:0][7:0] cnt;
      logic rr;
      logic [5:0] disp_v;
      logic [5:0][6:0] disp_rob;
      logic [5:0] disp_thr;
      logic [3:0] ret_v;
      logic [3:0][4:0] ret_dest;
      logic ret_thr;
   } ooo_state_t;
endpackage

/* ooo_issue_retire.sv */
// Out-of-order pipeline control: fetch, issue, dispatch, retire, flush.
// What this block does
// - Issue waits until scheduler, reorder and load/store space is free.
// - Only correct-path micro-operations retire and write registers.
// - A misprediction discards wrong-path work and restarts the path.
// - An instruction retires once all its micro-operations are done, or a full window of them for very long ones.
// - Retirement is strictly in program order within a thread.
// - Younger ready work dispatches past a stalled oldest entry and waits done in the reorder buffer.
// - The scheduler has 36 entries, with some kept per thread in dual mode.
// - In single-thread mode all scheduler entries serve the one thread.
// - The reorder buffer has 128 slots, halved per thread in dual mode.
// - Up to six micro-operations dispatch per cycle, one per port.
// - Fetch asks the instruction cache for at most sixteen bytes a cycle.
// - Fetch is sixteen-byte aligned and yields only the block's remainder.
// - Fetch addresses translate through a 128-entry translation buffer.
// - At most four instructions are issued per cycle.
// - Wrong-path entries are removed in place without stalling others.
`include "ooo_consts.svh"
module ooo_issue_retire (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic dual_thread_mode_i,
   output logic icache_req_o,
   output logic [31:0] icache_addr_o,
   output logic [4:0] icache_bytes_o,
   input wire logic icache_ack_i,
   input wire logic pred_taken_i,
   input wire logic [31:0] pred_target_i,
   output logic itb_miss_o,
   output logic [31:0] itb_miss_va_o,
   input wire logic itb_fill_i,
   input wire logic [31:0] itb_fill_va_i,
   input wire logic [19:0] itb_fill_pa_i,
   input wire logic [3:0] dec_valid_i,
   input wire logic dec_thread_i,
   input wire logic [3:0] dec_load_i,
   input wire logic [3:0] dec_store_i,
   input wire logic [3:0] dec_last_i,
   input wire logic [3:0][4:0] dec_dest_i,
   input wire logic [3:0][2:0] dec_port_i,
   input wire logic [3:0] dec_dep_v_i,
   input wire logic [3:0][6:0] dec_dep_i,
   output logic dec_ready_o,
   output logic [3:0][6:0] issue_rob_o,
   input wire logic [2:0] lb_free_i,
   input wire logic [2:0] sb_free_i,
   output logic [5:0] disp_valid_o,
   output logic [5:0][6:0] disp_rob_o,
   output logic [5:0] disp_thread_o,
   input wire logic [5:0] done_valid_i,
   input wire logic [5:0][6:0] done_rob_i,
   input wire logic mispredict_i,
   input wire logic mis_thread_i,
   input wire logic [6:0] mis_rob_i,
   input wire logic [31:0] redirect_pc_i,
   output logic fe_flush_o,
   output logic [3:0] ret_valid_o,
   output logic [3:0][4:0] ret_dest_o,
   output logic ret_thread_o
);
   import ooo_pkg::*;

   ooo_state_t q;
   ooo_state_t d;

   // Distance of a slot from its thread's oldest entry.
   function automatic logic [6:0] age(input logic [6:0] s,
                                      input logic [6:0] h,
                                      input logic dl);
      age = dl ? {1'b0, s[5:0] - h[5:0]} : s - h;
   endfunction

   // Step a pointer, wrapping inside the thread's half in dual mode.
   function automatic logic [6:0] nxt(input logic [6:0] p,
                                      input logic [2:0] k,
                                      input logic dl);
      nxt = dl ? {p[6], p[5:0] + {3'h0, k}} : p + {4'h0, k};
   endfunction

   assign fe_flush_o = mispredict_i;
   assign disp_valid_o = q.disp_v;
   assign disp_rob_o = q.disp_rob;
   assign disp_thread_o = q.disp_thr;
   assign ret_valid_o = q.ret_v;
   assign ret_dest_o = q.ret_dest;
   assign ret_thread_o = q.ret_thr;

   always_comb begin
      logic dl;
      logic hit;
      ooo_itb_ent_t ie;
      logic tm;
      logic [6:0] ma;
      logic [35:0] kill;
      logic [35:0][6:0] ra;
      logic found;
      logic [5:0] best;
      logic tr;
      logic run;
      logic ok;
      logic [2:0] nret;
      logic [6:0] s;
      logic t;
      logic [2:0] n;
      logic [2:0] nld;
      logic [2:0] nst;
      logic [5:0] rs_used;
      logic [5:0] rs_oth;
      logic [5:0] rs_short;
      logic [6:0] tail;
      d = q;
      dl = dual_thread_mode_i;
      ie = q.itb[q.pc[18:12]];
      hit = ie.v && ie.tag == q.pc[31:19];
      tm = dl & mis_thread_i;
      ma = age(mis_rob_i, q.head[tm], dl);
      kill = '0;
      ra = '0;
      found = 1'b0;
      best = '0;
      tr = dl & q.rr;
      run = 1'b1;
      ok = 1'b0;
      nret = '0;
      s = '0;
      t = dl & dec_thread_i;
      n = '0;
      nld = '0;
      nst = '0;
      rs_used = '0;
      rs_oth = '0;
      rs_short = '0;
      tail = '0;

      // Translated fetch of one aligned block per accepted request.
      icache_req_o = q.fst == OOO_F_RUN && hit && !mispredict_i;
      icache_addr_o = {ie.ppn, q.pc[11:4], 4'h0};
      icache_bytes_o = `OOO_FETCH_B - {1'b0, q.pc[3:0]};
      itb_miss_o = q.fst == OOO_F_WALK;
      itb_miss_va_o = q.pc;
      case (q.fst)
         OOO_F_RUN: begin
            if (!hit) begin
               d.fst = OOO_F_WALK;
            end else if (icache_ack_i && icache_req_o) begin
               d.pc = pred_taken_i ? pred_target_i
                                   : {q.pc[31:4] + 28'h1, 4'h0};
            end
         end
         OOO_F_WALK: begin
            if (itb_fill_i) begin
               d.fst = OOO_F_RUN;
            end
         end
         default: begin
            d.fst = OOO_F_RUN;
         end
      endcase
      if (itb_fill_i) begin
         d.itb[itb_fill_va_i[18:12]].v = 1'b1;
         d.itb[itb_fill_va_i[18:12]].tag = itb_fill_va_i[31:19];
         d.itb[itb_fill_va_i[18:12]].ppn = itb_fill_pa_i;
      end
      if (mispredict_i) begin
         d.pc = redirect_pc_i;
         d.fst = OOO_F_RUN;
      end

      // Completion marks results done and wakes waiting consumers.
      for (int p = 0; p < `OOO_PORTS; p++) begin
         if (done_valid_i[p] && q.reorder_buffer[done_rob_i[p]].v) begin
            d.reorder_buffer[done_rob_i[p]].done = 1'b1;
         end
      end
      for (int e = 0; e < `OOO_RS_N; e++) begin
         for (int p = 0; p < `OOO_PORTS; p++) begin
            if (done_valid_i[p] && q.rs[e].dep == done_rob_i[p]) begin
               d.rs[e].dv = 1'b0;
            end
         end
         ra[e] = age(q.rs[e].reorder_buffer, q.head[q.rs[e].thr], dl);
         kill[e] = mispredict_i && q.rs[e].v && q.rs[e].thr == tm
                   && ra[e] > ma;
         rs_used = rs_used + {5'h0, q.rs[e].v};
         rs_oth = rs_oth + {5'h0, q.rs[e].v && q.rs[e].thr != t};
      end

      // Each port takes its oldest ready entry, independent of the others.
      d.disp_v = '0;
      for (int p = 0; p < `OOO_PORTS; p++) begin
         found = 1'b0;
         best = '0;
         for (int e = 0; e < `OOO_RS_N; e++) begin
            if (q.rs[e].v && !q.rs[e].dv && q.rs[e].port == 3'(p)
                && !kill[e] && (!found || ra[e] < ra[best])) begin
               found = 1'b1;
               best = 6'(e);
            end
         end
         if (found) begin
            d.rs[best].v = 1'b0;
            d.disp_v[p] = 1'b1;
            d.disp_rob[p] = q.rs[best].reorder_buffer;
            d.disp_thr[p] = q.rs[best].thr;
         end
      end

      // Retirement alternates threads and stops at the first unfinished slot.
      d.rr = ~q.rr;
      for (int k = 0; k < `OOO_WIDTH; k++) begin
         s = nxt(q.head[tr], 3'(k), dl);
         ok = 8'(k) < q.cnt[tr] && q.reorder_buffer[s].done
              && !(mispredict_i && tm == tr
                   && age(s, q.head[tr], dl) > ma);
         if (run && ok) begin
            if (q.reorder_buffer[s].last) begin
               nret = 3'(k + 1);
            end
         end else begin
            run = 1'b0;
         end
      end
      if (run && nret == 3'h0) begin
         nret = 3'h4;
      end
      d.ret_v = '0;
      d.ret_thr = tr;
      for (int k = 0; k < `OOO_WIDTH; k++) begin
         s = nxt(q.head[tr], 3'(k), dl);
         if (3'(k) < nret) begin
            d.reorder_buffer[s].v = 1'b0;
            d.ret_v[k] = 1'b1;
            d.ret_dest[k] = q.reorder_buffer[s].dest;
         end
      end
      d.head[tr] = nxt(q.head[tr], nret, dl);
      d.cnt[tr] = q.cnt[tr] - {5'h0, nret};

      // A flush drops everything younger than the branch, in place.
      if (mispredict_i) begin
         for (int i = 0; i < `OOO_ROB_N; i++) begin
            s = 7'(i);
            if ((!dl || s[6] == tm) && q.reorder_buffer[i].v
                && age(s, q.head[tm], dl) > ma) begin
               d.reorder_buffer[i].v = 1'b0;
            end
         end
         d.cnt[tm] = {1'b0, ma} + 8'h01
                     - ((tr == tm) ? {5'h0, nret} : 8'h00);
         for (int e = 0; e < `OOO_RS_N; e++) begin
            if (kill[e]) begin
               d.rs[e].v = 1'b0;
            end
         end
      end

      // Issue takes the whole decoded group or none of it.
      for (int k = 0; k < `OOO_WIDTH; k++) begin
         n = n + {2'h0, dec_valid_i[k]};
         nld = nld + {2'h0, dec_valid_i[k] && dec_load_i[k]};
         nst = nst + {2'h0, dec_valid_i[k] && dec_store_i[k]};
      end
      // Keeping the other thread's reserve free is what stops lock-out.
      if (dl && rs_oth < `OOO_RS_RSV) begin
         rs_short = `OOO_RS_RSV - rs_oth;
      end
      dec_ready_o = !mispredict_i
         && q.cnt[t] + {5'h0, n} <= (dl ? `OOO_ROB_CAP2
                                       : `OOO_ROB_CAP1)
         && {3'h0, n} + rs_short <= `OOO_RS_FULL - rs_used
         && nld <= lb_free_i && nst <= sb_free_i;
      tail = dl ? {q.head[t][6], q.head[t][5:0] + q.cnt[t][5:0]}
                : q.head[t] + q.cnt[t][6:0];
      for (int k = 0; k < `OOO_WIDTH; k++) begin
         issue_rob_o[k] = nxt(tail, 3'(k), dl);
         if (dec_valid_i[k] && dec_ready_o) begin
            s = issue_rob_o[k];
            d.reorder_buffer[s].v = 1'b1;
            d.reorder_buffer[s].done = 1'b0;
            d.reorder_buffer[s].last = dec_last_i[k];
            d.reorder_buffer[s].dest = dec_dest_i[k];
            found = 1'b0;
            for (int e = 0; e < `OOO_RS_N; e++) begin
               if (!found && !d.rs[e].v) begin
                  found = 1'b1;
                  d.rs[e].v = 1'b1;
                  d.rs[e].thr = t;
                  d.rs[e].reorder_buffer = s;
                  d.rs[e].port = dec_port_i[k];
                  d.rs[e].dep = dec_dep_i[k];
                  d.rs[e].dv = dec_dep_v_i[k] && d.reorder_buffer[dec_dep_i[k]].v
                               && !d.reorder_buffer[dec_dep_i[k]].done;
               end
            end
         end
      end
      if (dec_ready_o) begin
         d.cnt[t] = d.cnt[t] + {5'h0, n};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.pc <= `OOO_RESET_PC;
         q.head[1] <= `OOO_T1_BASE;
      end else begin
         q <= d;
      end
   end
endmodule

/* ooo_far_model.sv */
// Far-side model: instruction cache, translation walker, execution ports.
module ooo_far_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic req_i,
   output logic ack_o,
   input wire logic miss_i,
   input wire logic [31:0] miss_va_i,
   output logic fill_o,
   output logic [31:0] fill_va_o,
   output logic [19:0] fill_pa_o,
   input wire logic [5:0] disp_i,
   input wire logic [5:0][6:0] disp_rob_i,
   input wire logic [5:0] hold_i,
   output logic [5:0] done_o,
   output logic [5:0][6:0] done_rob_o
);
   logic tog_q;
   logic [5:0] pend_q;
   logic [5:0][6:0] rob_q;
   // A slow cache only answers on every other cycle.
   assign ack_o = req_i & (~slow_i | tog_q);
   always_ff @(posedge clk_i) begin
      tog_q <= ~tog_q & ~rst_i;
      fill_o <= miss_i & ~fill_o & ~rst_i;
      // Identity mapping; the address lines toggle while no miss is requested.
      fill_va_o <= miss_i ? miss_va_i : ~fill_va_o;
      fill_pa_o <= miss_i ? miss_va_i[31:12] : ~fill_pa_o;
      for (int p = 0; p < 6; p++) begin
         if (rst_i | done_o[p]) begin
            pend_q[p] <= 1'b0;
         end
         if (disp_i[p]) begin
            pend_q[p] <= 1'b1;
            rob_q[p] <= disp_rob_i[p];
         end
      end
   end
   // A held port models an operation waiting on memory.
   always_comb begin
      for (int p = 0; p < 6; p++) begin
         done_o[p] = pend_q[p] & ~hold_i[p];
         done_rob_o[p] = done_o[p] ? rob_q[p] : ~rob_q[p];
      end
   end
endmodule

/* ooo_issue_retire_chk.sv */
// Port assertions for the issue and retirement control block.
module ooo_issue_retire_chk (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic dual_thread_mode_i,
   input wire logic icache_req_o,
   input wire logic [31:0] icache_addr_o,
   input wire logic [4:0] icache_bytes_o,
   input wire logic icache_ack_i,
   input wire logic pred_taken_i,
   input wire logic itb_miss_o,
   input wire logic itb_fill_i,
   input wire logic [3:0] dec_valid_i,
   input wire logic [3:0] dec_load_i,
   input wire logic [2:0] lb_free_i,
   input wire logic dec_ready_o,
   input wire logic [3:0][6:0] issue_rob_o,
   input wire logic mispredict_i,
   input wire logic fe_flush_o,
   input wire logic [3:0] ret_valid_o,
   input wire logic ret_thread_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence acc_seq;
      icache_req_o && icache_ack_i && !pred_taken_i && !mispredict_i;
   endsequence
   fetch_align_a: assert property (
      icache_req_o |-> icache_addr_o[3:0] == 4'h0)
      else $error("fetch address not aligned");
   fetch_width_a: assert property (
      icache_req_o |-> icache_bytes_o != 5'h00 && icache_bytes_o <= 5'h10)
      else $error("fetch byte count out of range");
   next_block_a: assert property (
      acc_seq ##1 icache_req_o |-> icache_bytes_o == 5'h10)
      else $error("sequential fetch not a full block");
   miss_hold_a: assert property (
      itb_miss_o && !itb_fill_i && !mispredict_i |=> itb_miss_o)
      else $error("miss dropped without fill");
   miss_quiet_a: assert property (
      itb_miss_o |-> !icache_req_o)
      else $error("fetch during translation miss");
   flush_block_a: assert property (
      mispredict_i |-> fe_flush_o && !dec_ready_o)
      else $error("mispredict did not flush");
   load_gate_a: assert property (
      $countones(dec_load_i & dec_valid_i) > lb_free_i |-> !dec_ready_o)
      else $error("issue without load buffers");
   slot_seq_a: assert property (
      !dual_thread_mode_i && dec_valid_i[1] |->
      issue_rob_o[1] == issue_rob_o[0] + 7'h01)
      else $error("reorder slots not consecutive");
   ret_prefix_a: assert property (
      ret_valid_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
      else $error("retire lanes not a prefix");
   single_thr_a: assert property (
      !dual_thread_mode_i && |ret_valid_o |-> !ret_thread_o)
      else $error("retire from absent thread");
endmodule
bind ooo_issue_retire ooo_issue_retire_chk chk (
   .sys_clk_i(sys_clk_i),
   .rst_i(rst_i),
   .dual_thread_mode_i(dual_thread_mode_i),
   .icache_req_o(icache_req_o),
   .icache_addr_o(icache_addr_o),
   .icache_bytes_o(icache_bytes_o),
   .icache_ack_i(icache_ack_i),
   .pred_taken_i(pred_taken_i),
   .itb_miss_o(itb_miss_o),
   .itb_fill_i(itb_fill_i),
   .dec_valid_i(dec_valid_i),
   .dec_load_i(dec_load_i),
   .lb_free_i(lb_free_i),
   .dec_ready_o(dec_ready_o),
   .issue_rob_o(issue_rob_o),
   .mispredict_i(mispredict_i),
   .fe_flush_o(fe_flush_o),
   .ret_valid_o(ret_valid_o),
   .ret_thread_o(ret_thread_o)
);

/* test_out_of_order_issue_retire.sv */
// Self-checking testbench for the issue and retirement control block.
module test_out_of_order_issue_retire;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i, rst_i, dual_thread_mode_i, icache_req_o, icache_ack_i;
   logic pred_taken_i, itb_miss_o, itb_fill_i, dec_thread_i, dec_ready_o;
   logic mispredict_i, mis_thread_i, fe_flush_o, ret_thread_o, slow;
   logic [31:0] icache_addr_o, pred_target_i, itb_miss_va_o, itb_fill_va_i;
   logic [31:0] redirect_pc_i;
   logic [4:0] icache_bytes_o;
   logic [19:0] itb_fill_pa_i;
   logic [3:0] dec_valid_i, dec_load_i, dec_store_i, dec_last_i, dec_dep_v_i;
   logic [3:0] ret_valid_o;
   logic [3:0][4:0] dec_dest_i, ret_dest_o;
   logic [3:0][2:0] dec_port_i;
   logic [3:0][6:0] dec_dep_i, issue_rob_o;
   logic [2:0] lb_free_i, sb_free_i;
   logic [5:0] disp_valid_o, disp_thread_o, done_valid_i, hold;
   logic [5:0][6:0] disp_rob_o, done_rob_i;
   logic [6:0] mis_rob_i, tail, b;
   logic rt;
   logic [4:0] rq[$];
   int fails, tests_run;
   ooo_issue_retire dut (.*);
   ooo_far_model far (.clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow),
      .req_i(icache_req_o), .ack_o(icache_ack_i), .miss_i(itb_miss_o),
      .miss_va_i(itb_miss_va_o), .fill_o(itb_fill_i),
      .fill_va_o(itb_fill_va_i), .fill_pa_o(itb_fill_pa_i),
      .disp_i(disp_valid_o), .disp_rob_i(disp_rob_o), .hold_i(hold),
      .done_o(done_valid_i), .done_rob_o(done_rob_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      for (int k = 0; k < 4; k++) begin
         if (ret_valid_o[k] === 1'b1) begin
            rq.push_back(ret_dest_o[k]);
            rt = ret_thread_o;
         end
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic iss(input logic [3:0] v, ld, st, input logic [3:0][2:0] p,
                      input logic [3:0][4:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      dec_valid_i <= v;
      dec_load_i <= ld;
      dec_store_i <= st;
      dec_port_i <= p;
      dec_dest_i <= d;
      do @(negedge sys_clk_i); while (dec_ready_o !== 1'b1 && ++n < 50);
      check(dec_ready_o, 1'b1);
      check(issue_rob_o[0], tail);
      @(posedge sys_clk_i);
      dec_valid_i <= 4'h0;
      tail = tail + 7'($countones(v));
   endtask
   task automatic t_fetch();
      int n;
      n = 0;
      do @(negedge sys_clk_i); while (icache_req_o !== 1'b1 && ++n < 20);
      check(icache_req_o, 1'b1);
      check(icache_addr_o, 32'h0000_0000);
      check(icache_bytes_o, 5'h10);
      @(posedge sys_clk_i);
      pred_taken_i <= 1'b1;
      pred_target_i <= 32'h0000_0004;
      @(posedge sys_clk_i);
      pred_taken_i <= 1'b0;
      @(negedge sys_clk_i);
      check(icache_bytes_o, 5'h0c);
      $display("fetch test done");
   endtask
   task automatic t_load();
      rq.delete();
      @(posedge sys_clk_i);
      lb_free_i <= 3'h0;
      dec_valid_i <= 4'h1;
      dec_load_i <= 4'h1;
      repeat (3) @(negedge sys_clk_i);
      check(dec_ready_o, 1'b0);
      // Withdraw the held group so that it is not taken twice.
      @(posedge sys_clk_i);
      dec_valid_i <= 4'h0;
      lb_free_i <= 3'h4;
      iss(4'h1, 4'h1, 4'h0, {4{3'h2}}, {4{5'h09}});
      repeat (8) @(posedge sys_clk_i);
      check(rq.size(), 1);
      check(rq[0], 5'h09);
      $display("load gate test done");
   endtask
   task automatic t_order();
      rq.delete();
      hold <= 6'h01;
      slow <= 1'b1;
      iss(4'h3, 4'h0, 4'h2, {6'h00, 3'h1, 3'h0}, {10'h000, 5'h02, 5'h01});
      repeat (2) @(negedge sys_clk_i);
      check(disp_valid_o, 6'h03);
      check(disp_rob_o[1], 7'h02);
      repeat (8) @(posedge sys_clk_i);
      check(rq.size(), 0);
      hold <= 6'h00;
      repeat (6) @(posedge sys_clk_i);
      check(rq.size(), 2);
      check(rq[0], 5'h01);
      check(rq[1], 5'h02);
      $display("order test done");
   endtask
   task automatic t_flush();
      rq.delete();
      hold <= 6'h01;
      b = tail;
      iss(4'h7, 4'h0, 4'h0, {3'h0, 3'h0, 3'h0, 3'h1},
          {5'h00, 5'h07, 5'h06, 5'h05});
      mispredict_i <= 1'b1;
      mis_rob_i <= b;
      // The redirect lands in an untranslated page, so fetch must walk.
      redirect_pc_i <= 32'h0000_102f;
      @(negedge sys_clk_i);
      check(fe_flush_o, 1'b1);
      check(dec_ready_o, 1'b0);
      @(posedge sys_clk_i);
      mispredict_i <= 1'b0;
      @(negedge sys_clk_i);
      check(icache_bytes_o, 5'h01);
      check(disp_valid_o, 6'h02);
      @(negedge sys_clk_i);
      check(itb_miss_o, 1'b1);
      check(itb_miss_va_o, 32'h0000_102f);
      repeat (2) @(negedge sys_clk_i);
      check(icache_addr_o, 32'h0000_1020);
      @(posedge sys_clk_i);
      hold <= 6'h00;
      repeat (9) @(posedge sys_clk_i);
      check(rq.size(), 1);
      check(rq[0], 5'h05);
      tail = b + 7'h01;
      $display("flush test done");
   endtask
   task automatic t_dual();
      rq.delete();
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      dual_thread_mode_i <= 1'b1;
      dec_thread_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(negedge sys_clk_i);
      check(issue_rob_o[0], 7'h40);
      check(dec_ready_o, 1'b1);
      tail = 7'h40;
      iss(4'h1, 4'h0, 4'h0, {4{3'h3}}, {4{5'h0b}});
      repeat (2) @(negedge sys_clk_i);
      check(disp_valid_o, 6'h08);
      check(disp_thread_o, 6'h08);
      check(disp_rob_o[3], 7'h40);
      repeat (8) @(posedge sys_clk_i);
      check(rq.size(), 1);
      check(rq[0], 5'h0b);
      check(rt, 1'b1);
      $display("dual thread test done");
   endtask
   initial begin
      #20000;
      fails++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
   initial begin
      {rst_i, slow, hold, tail} = {1'b1, 1'b0, 6'h00, 7'h00};
      {dual_thread_mode_i, dec_thread_i, pred_taken_i, mispredict_i} = 4'h0;
      {mis_thread_i, dec_valid_i, dec_load_i, dec_store_i} = 13'h0000;
      {dec_dep_v_i, dec_dep_i} = 32'h0000_0000;
      {dec_port_i, dec_dest_i} = 32'h0000_0000;
      {pred_target_i, redirect_pc_i, mis_rob_i} = 71'h00_0000_0000_0000_0000;
      dec_last_i = 4'hf;
      lb_free_i = 3'h4;
      sb_free_i = 3'h4;
      repeat (5) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_fetch();
      t_load();
      t_order();
      t_flush();
      t_dual();
      conclude();
   end
endmodule
